/* File: design/ruc_pkg.sv */
// constants, encodings and carrier types of the remote update configuration controller
package ruc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam int              ADDR_W        = 8;
    localparam logic [7:0]      OFF_CTRL      = 8'h00;
    localparam logic [7:0]      OFF_WD_TIME   = 8'h04;
    localparam logic [7:0]      OFF_STATUS    = 8'h08;
    localparam logic [7:0]      OFF_CMD       = 8'h0C;
    localparam logic [7:0]      OFF_WD_COUNT  = 8'h10;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int              PAGE_W        = 3;
    localparam int              CTRL_PAGE_LSB = 0;
    localparam int              CTRL_WDEN_BIT = 3;
    localparam int              CMD_RECFG_BIT = 0;
    localparam int              CMD_KICK_BIT  = 1;
    localparam int              ST_CAUSE_LSB  = 0;
    localparam int              ST_PAGE_LSB   = 4;
    localparam int              ST_FACT_BIT   = 8;
    localparam int              ST_USER_BIT   = 9;
    localparam int              ST_REMOTE_BIT = 10;
    localparam int              ST_WDEN_BIT   = 11;
    localparam int              ST_SCHBAD_BIT = 12;
    localparam logic [2:0]      FACTORY_PAGE  = 3'h0;
    localparam logic [2:0]      CTRL_PAGE_RST = 3'h1;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CAUSE_NONE, CAUSE_LOAD_ERR, CAUSE_WDOG, CAUSE_USER, CAUSE_PIN
    } ruc_cause_type;

    typedef enum logic [1:0] {
        SCHEME_SERIAL, SCHEME_SYNC_PAR, SCHEME_ASYNC_PAR, SCHEME_RSVD
    } ruc_scheme_type;

    typedef enum logic [1:0] {
        ST_POR, ST_LOAD, ST_INIT, ST_USER
    } ruc_state_type;

    // ------------------------------------------------------------
    // carriers towards the paged configuration store
    // ------------------------------------------------------------
    typedef struct packed {
        logic              start;
        logic [PAGE_W-1:0] page;
    } ruc_load_req_type;

    typedef struct packed {
        logic done;
        logic err;
    } ruc_load_rsp_type;

endpackage

/* File: design/ruc_ctrl.sv */
// remote update configuration controller: loader sequencer, user watchdog and apb registers
`timescale 1ns/1ps
`default_nettype none

module ruc_ctrl #(
    parameter int               WD_W       = 24,
    parameter logic [2:0]       LOCAL_PAGE = 3'h1
) (
    // clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // apb slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [ruc_pkg::ADDR_W-1:0]        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // straps and reconfiguration pin
    input  wire logic                              strap_remote_mode,
    input  wire logic [1:0]                        strap_scheme,
    input  wire logic                              strap_mem_source,
    input  wire logic                              reconfig_n,
    // paged configuration store
    output ruc_pkg::ruc_load_req_type              load_req,
    input  wire ruc_pkg::ruc_load_rsp_type         load_rsp,
    // device state
    output logic                                   io_enable,
    output logic                                   user_rst,
    output logic                                   user_mode,
    output logic                                   app_active
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (WD_W < 1 || WD_W > 32) begin : g_bad_wd_w
        $error("ruc_ctrl: WD_W must lie in 1..32");
    end
    if (LOCAL_PAGE == ruc_pkg::FACTORY_PAGE) begin : g_bad_local
        $error("ruc_ctrl: LOCAL_PAGE must not be the factory page");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ruc_pkg::ruc_state_type       state;
        logic [1:0]                   remote_s;
        logic [1:0][1:0]              scheme_s;
        logic [1:0]                   memsrc_s;
        logic [2:0]                   recfg_s;
        logic [1:0]                   done_s;
        logic [1:0]                   err_s;
        logic                         remote;
        logic                         factory;
        logic                         scheme_bad;
        logic [1:0]                   por_fill;        // strap synchronisers filled
        logic                         armed;           // previous load answer drained
        ruc_pkg::ruc_load_req_type    load;
        ruc_pkg::ruc_cause_type       cause;
        logic [2:0]                   ctrl_page;
        logic                         wd_en;
        logic [WD_W-1:0]              wd_time;
        logic [WD_W-1:0]              wd_cnt;
        logic                         recfg_req;
        logic                         io_en;
        logic                         urst;
        logic [31:0]                  rdata;
        logic                         slverr;
    } ruc_regs_type;

    ruc_regs_type state_r;
    ruc_regs_type state_nxt;

    // register index decode for the error flag, set in setup for both reads and writes
    function automatic logic known_addr(input logic [ruc_pkg::ADDR_W-1:0] a);
        known_addr = (a == ruc_pkg::OFF_CTRL)   || (a == ruc_pkg::OFF_WD_TIME) ||
                     (a == ruc_pkg::OFF_STATUS) || (a == ruc_pkg::OFF_CMD)     ||
                     (a == ruc_pkg::OFF_WD_COUNT);
    endfunction

    // start a load of the given page: one-cycle request pulse, pins released
    function automatic ruc_regs_type begin_load(input ruc_regs_type s, input logic [2:0] pg);
        ruc_regs_type t;
        t            = s;
        t.state      = ruc_pkg::ST_LOAD;
        t.load.start = 1'b1;
        t.load.page  = pg;
        t.io_en      = 1'b0;
        t.armed      = 1'b0;                                  // stale answers ignored
        begin_load   = t;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    logic setup_ph;
    logic wr_acc;
    logic wd_run;
    logic kick;
    logic pin_edge;

    always_comb begin
        state_nxt            = state_r;
        state_nxt.load.start = 1'b0;
        state_nxt.urst       = 1'b0;

        // two-flop synchronisers for the straps and load answer, three flops for the reconfiguration pin
        state_nxt.remote_s  = {state_r.remote_s[0], strap_remote_mode};
        state_nxt.scheme_s  = {state_r.scheme_s[0], strap_scheme};
        state_nxt.memsrc_s  = {state_r.memsrc_s[0], strap_mem_source};
        state_nxt.recfg_s   = {state_r.recfg_s[1:0], reconfig_n};
        state_nxt.done_s    = {state_r.done_s[0], load_rsp.done};
        state_nxt.err_s     = {state_r.err_s[0], load_rsp.err};
        // straps are trusted only after two edges of synchronisation;
        // a reconfiguration pin restart finds them already filled
        state_nxt.por_fill  = {state_r.por_fill[0], 1'b1};
        // falling edge seen between the second and third flops only
        pin_edge = state_r.recfg_s[2] & ~state_r.recfg_s[1];

        setup_ph = psel & ~penable;
        wr_acc   = psel & penable & pwrite;

        // watchdog runs only for an application image, never for factory
        wd_run = (state_r.state == ruc_pkg::ST_USER) & state_r.wd_en & ~state_r.factory;
        kick   = wr_acc && paddr == ruc_pkg::OFF_CMD && pwdata[ruc_pkg::CMD_KICK_BIT]
                 && wd_run && state_r.remote;

        // read data and error captured in setup so the access phase can finish at once
        if (setup_ph) begin
            state_nxt.slverr = ~known_addr(paddr);
            state_nxt.rdata  = 32'h0000_0000;
            unique case (paddr)
                ruc_pkg::OFF_CTRL: begin
                    state_nxt.rdata[ruc_pkg::CTRL_PAGE_LSB +: ruc_pkg::PAGE_W] = state_r.ctrl_page;
                    state_nxt.rdata[ruc_pkg::CTRL_WDEN_BIT] = state_r.wd_en;
                end
                ruc_pkg::OFF_WD_TIME: begin
                    state_nxt.rdata[WD_W-1:0] = state_r.wd_time;
                end
                ruc_pkg::OFF_STATUS: begin
                    state_nxt.rdata[ruc_pkg::ST_CAUSE_LSB +: $bits(ruc_pkg::ruc_cause_type)] = state_r.cause;
                    state_nxt.rdata[ruc_pkg::ST_PAGE_LSB +: ruc_pkg::PAGE_W] = state_r.load.page;
                    state_nxt.rdata[ruc_pkg::ST_FACT_BIT]   = state_r.factory;
                    state_nxt.rdata[ruc_pkg::ST_USER_BIT]   = (state_r.state == ruc_pkg::ST_USER);
                    state_nxt.rdata[ruc_pkg::ST_REMOTE_BIT] = state_r.remote;
                    state_nxt.rdata[ruc_pkg::ST_WDEN_BIT]   = state_r.wd_en;
                    state_nxt.rdata[ruc_pkg::ST_SCHBAD_BIT] = state_r.scheme_bad;
                end
                ruc_pkg::OFF_WD_COUNT: begin
                    state_nxt.rdata[WD_W-1:0] = state_r.wd_cnt;
                end
                default: begin
                    state_nxt.rdata = 32'h0000_0000;              // cmd and holes read zero
                end
            endcase
        end

        // register writes take effect at the completing edge
        if (wr_acc) begin
            unique case (paddr)
                ruc_pkg::OFF_CTRL: begin
                    state_nxt.ctrl_page = pwdata[ruc_pkg::CTRL_PAGE_LSB +: ruc_pkg::PAGE_W];
                    state_nxt.wd_en     = pwdata[ruc_pkg::CTRL_WDEN_BIT];
                end
                ruc_pkg::OFF_WD_TIME: begin
                    state_nxt.wd_time = pwdata[WD_W-1:0];
                end
                ruc_pkg::OFF_CMD: begin
                    if (pwdata[ruc_pkg::CMD_RECFG_BIT]) begin
                        state_nxt.recfg_req = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // loader sequence
        unique case (state_r.state)
            ruc_pkg::ST_POR: begin
                state_nxt.io_en   = 1'b0;
                state_nxt.remote  = state_r.remote_s[1];
                // a memory source cannot drive the asynchronous parallel scheme
                state_nxt.scheme_bad = (state_r.scheme_s[1] == ruc_pkg::SCHEME_RSVD) ||
                                       (state_r.memsrc_s[1] &&
                                        state_r.scheme_s[1] == ruc_pkg::SCHEME_ASYNC_PAR);
                // before the fill the stages still hold reset values, not the pins
                if (!state_nxt.scheme_bad && state_r.por_fill[1]) begin
                    state_nxt = begin_load(state_nxt, state_r.remote_s[1] ?
                                           ruc_pkg::FACTORY_PAGE : LOCAL_PAGE);
                end
            end
            ruc_pkg::ST_LOAD: begin
                // the answer to an earlier start may still stand in the synchronisers;
                // listen only once both lines have been seen low since this start
                if (!state_r.armed) begin
                    state_nxt.armed = ~state_r.err_s[1] & ~state_r.done_s[1];
                end else if (state_r.err_s[1]) begin
                    if (state_r.load.page != ruc_pkg::FACTORY_PAGE) begin
                        state_nxt.cause = ruc_pkg::CAUSE_LOAD_ERR;
                    end
                    // a failing factory image is simply retried
                    state_nxt = begin_load(state_nxt, ruc_pkg::FACTORY_PAGE);
                end else if (state_r.done_s[1]) begin
                    state_nxt.state = ruc_pkg::ST_INIT;
                end
            end
            ruc_pkg::ST_INIT: begin
                state_nxt.io_en   = 1'b1;
                state_nxt.urst    = 1'b1;
                state_nxt.factory = (state_r.load.page == ruc_pkg::FACTORY_PAGE);
                state_nxt.wd_cnt  = state_r.wd_time;
                state_nxt.recfg_req = 1'b0;
                state_nxt.state   = ruc_pkg::ST_USER;
            end
            ruc_pkg::ST_USER: begin
                if (wd_run && state_r.wd_cnt == '0) begin
                    state_nxt.cause = ruc_pkg::CAUSE_WDOG;
                    state_nxt = begin_load(state_nxt, ruc_pkg::FACTORY_PAGE);
                end else if (state_r.recfg_req) begin
                    state_nxt.recfg_req = 1'b0;
                    state_nxt.cause     = ruc_pkg::CAUSE_USER;
                    // factory in remote mode launches the chosen page, any other image returns to factory
                    state_nxt = begin_load(state_nxt, (state_r.factory && state_r.remote) ?
                                           state_r.ctrl_page : ruc_pkg::FACTORY_PAGE);
                end else if (kick) begin
                    state_nxt.wd_cnt = state_r.wd_time;
                end else if (wd_run) begin
                    state_nxt.wd_cnt = state_r.wd_cnt - 1'b1;
                end
            end
        endcase

        // the reconfiguration pin forces a fresh power-up sequence from any state
        if (pin_edge) begin
            state_nxt.state      = ruc_pkg::ST_POR;
            state_nxt.io_en      = 1'b0;
            state_nxt.load.start = 1'b0;
            state_nxt.cause      = ruc_pkg::CAUSE_PIN;
            state_nxt.recfg_req  = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r            <= '0;
            state_r.state      <= ruc_pkg::ST_POR;
            state_r.recfg_s    <= 3'h7;                  // pin idles high, no false edge
            state_r.remote_s   <= 2'h3;
            state_r.remote     <= 1'b1;
            state_r.cause      <= ruc_pkg::CAUSE_NONE;
            state_r.ctrl_page  <= ruc_pkg::CTRL_PAGE_RST;
            state_r.load.page  <= ruc_pkg::FACTORY_PAGE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // zero-wait slave: data was prepared during the setup cycle
    assign pready     = 1'b1;
    assign prdata     = state_r.rdata;
    assign pslverr    = state_r.slverr;
    assign load_req   = state_r.load;
    assign io_enable  = state_r.io_en;
    assign user_rst   = state_r.urst;
    assign user_mode  = (state_r.state == ruc_pkg::ST_USER);
    assign app_active = (state_r.state == ruc_pkg::ST_USER) & ~state_r.factory;

endmodule

`default_nettype wire

/* File: bench/ruc_ctrl_chk.sv */
// port assertions for the remote update controller
`timescale 1ns/1ps
`default_nettype none
module ruc_ctrl_chk #(
    parameter int         WD_W       = 24,
    parameter logic [2:0] LOCAL_PAGE = 3'h1
) (
    // clock and reset
    input wire logic                     pclk,
    input wire logic                     presetn,
    // apb
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic [7:0]               paddr,
    input wire logic                     pslverr,
    // store and state
    input wire ruc_pkg::ruc_load_req_type load_req,
    input wire logic                     io_enable,
    input wire logic                     user_rst,
    input wire logic                     user_mode,
    input wire logic                     app_active
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a load request is a single-cycle strobe
    sequence s_start_pulse;
        load_req.start ##1 !load_req.start;
    endsequence
    chk_start_pulse: assert property (load_req.start |-> s_start_pulse) else $error("start not a pulse");
    chk_pins_off: assert property (load_req.start |=> !io_enable) else $error("pins on in load");
    chk_leave_user: assert property (load_req.start |=> !user_mode) else $error("user mode in load");
    chk_init_pins: assert property (user_rst |-> io_enable) else $error("reset without pins");
    chk_user_pulse: assert property (user_rst |=> !user_rst) else $error("user reset too long");
    chk_init_user: assert property (user_rst |-> ##[0:1] user_mode) else $error("no user mode after init");
    chk_fact_wdog: assert property (user_mode && load_req.page == ruc_pkg::FACTORY_PAGE |-> !app_active)
        else $error("factory image counted as app");
    chk_app_page: assert property (app_active |-> user_mode && load_req.page != ruc_pkg::FACTORY_PAGE)
        else $error("app active outside app");
    chk_page_hold: assert property ($changed(load_req.page) |-> load_req.start) else $error("page moved");
    // beyond the last register the slave must flag an error
    chk_unmapped: assert property (psel && !penable && paddr > ruc_pkg::OFF_WD_COUNT |=> pslverr)
        else $error("no error on unmapped");
endmodule
bind ruc_ctrl ruc_ctrl_chk #(.WD_W(WD_W), .LOCAL_PAGE(LOCAL_PAGE)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr), .load_req(load_req),
    .io_enable(io_enable), .user_rst(user_rst), .user_mode(user_mode), .app_active(app_active));
`default_nettype wire

/* File: bench/ruc_store_model.sv */
// behavioural paged configuration store answering load requests
`timescale 1ns/1ps
`default_nettype none
module ruc_store_model (
    // clock
    input wire logic                      pclk,
    // load link
    input wire ruc_pkg::ruc_load_req_type load_req,
    output ruc_pkg::ruc_load_rsp_type     load_rsp,
    // bench control: pages that fail and answer delay
    input wire logic [7:0]                fail_pages,
    input wire logic [3:0]                dly
);
    logic [4:0] cnt;
    logic       busy;
    logic       bad;
    initial begin
        busy = 1'b0;
        load_rsp = '0;
    end
    // ----------------------------------------
    // answer path
    // ----------------------------------------
    // no write port: page zero stays as built, pages are picked like a paged memory
    // a new start drops any answer still standing, as the link requires
    always @(posedge pclk) begin
        if (load_req.start) begin
            busy <= 1'b1;
            cnt <= 5'h00;
            bad <= fail_pages[load_req.page];
            load_rsp <= '0;
        end else if (busy) begin
            cnt <= cnt + 5'h01;
            if (cnt == {1'b0, dly}) load_rsp <= {~bad, bad};
            if (cnt == {1'b0, dly} + 5'h03) begin
                load_rsp <= '0;
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/remote_update_config_control_tb_top.sv */
// self-checking bench for the remote update controller
`timescale 1ns/1ps
`default_nettype none
module remote_update_config_control_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        strap_remote_mode, strap_mem_source, reconfig_n;
    logic        io_enable, user_rst, user_mode, app_active;
    logic [7:0]  paddr, fail_pages;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  strap_scheme;
    logic [3:0]  dly;
    int          err_total, checks, p, s;
    ruc_pkg::ruc_load_req_type load_req;
    ruc_pkg::ruc_load_rsp_type load_rsp;

    ruc_ctrl #(.WD_W(24), .LOCAL_PAGE(3'h1)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .strap_remote_mode(strap_remote_mode),
        .strap_scheme(strap_scheme), .strap_mem_source(strap_mem_source), .reconfig_n(reconfig_n),
        .load_req(load_req), .load_rsp(load_rsp), .io_enable(io_enable), .user_rst(user_rst),
        .user_mode(user_mode), .app_active(app_active));
    ruc_store_model u_store (.pclk(pclk), .load_req(load_req), .load_rsp(load_rsp),
        .fail_pages(fail_pages), .dly(dly));

    // ----------------------------------------
    // clock, watchdog, report
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // the whole sequence needs well under 10000 cycles
    initial begin
        #2000000;
        err_total++;
        $display("[FAIL] %0t bench timed out", $time);
        final_report();
    end
    task final_report();
        $display("mismatches %0d of %0d checks", err_total, checks);
        if (err_total == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------
    // access helpers
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench watchdog ends a wait for the answer
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input string m); apb(1'b0, a, 32'h0); chk(q, exp, m); endtask
    function automatic logic [31:0] st(logic [2:0] c, logic [2:0] pg, logic f, logic r, logic w);
        return {19'h0, 1'b0, w, r, 1'b1, f, 1'b0, pg, 1'b0, c};
    endfunction
    task do_reset();
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // waits for user mode to be left and entered again
    task automatic wait_user();
        int n;
        logic lo;
        lo = 1'b0;
        for (n = 0; n < 400; n++) begin
            @(posedge pclk);
            if (user_mode !== 1'b1) lo = 1'b1;
            else if (lo) break;
        end
        if (n == 400) chk(32'h0, 32'h1, "user mode not reached");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0; presetn = 0; reconfig_n = 1;
        strap_remote_mode = 1; strap_scheme = 2'h0; strap_mem_source = 1; fail_pages = 8'h00; dly = 4'h2;
        err_total = 0;
        checks = 0;
        do_reset();
        wait_user();
        chk({29'h0, load_req.page}, 32'h0, "first page");
        rd(ruc_pkg::OFF_STATUS, st(3'h0, 3'h0, 1, 1, 0), "factory status");
        chk({31'h0, app_active}, 32'h0, "factory app flag");
        rd(ruc_pkg::OFF_CTRL, 32'h0000_0001, "ctrl reset");
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(q, 32'h0, "unmapped data");
        wr(ruc_pkg::OFF_WD_TIME, 32'h0000_001E);
        rd(ruc_pkg::OFF_WD_TIME, 32'h0000_001E, "wd time");
        dly <= 4'h9;
        // every application page, watchdog armed on the last one
        for (p = 1; p < 8; p++) begin
            wr(ruc_pkg::OFF_CTRL, 32'(p) | ((p == 7) ? 32'h8 : 32'h0));
            wr(ruc_pkg::OFF_CMD, 32'h0000_0001);
            wait_user();
            rd(ruc_pkg::OFF_STATUS, st(3'h3, p[2:0], 0, 1, p == 7), "app status");
            chk({31'h0, app_active}, 32'h1, "app flag");
            if (p < 7) begin
                // an application hands control back to the factory image first
                wr(ruc_pkg::OFF_CMD, 32'h0000_0001);
                wait_user();
                rd(ruc_pkg::OFF_STATUS, st(3'h3, 3'h0, 1, 1, 0), "back to factory");
            end
        end
        dly <= 4'h2;
        // restarts keep the application alive and reload the count
        repeat (4) begin
            wr(ruc_pkg::OFF_CMD, 32'h0000_0002);
            apb(1'b0, ruc_pkg::OFF_WD_COUNT, 32'h0);
            chk({31'h0, (q <= 32'h1E && q >= 32'h1A)}, 32'h1, "count after restart");
            chk({31'h0, app_active}, 32'h1, "app kept alive");
            repeat (18) @(posedge pclk);
        end
        wait_user();
        rd(ruc_pkg::OFF_STATUS, st(3'h2, 3'h0, 1, 1, 1), "timeout status");
        chk({31'h0, app_active}, 32'h0, "wd off in factory");
        // failing application load falls back to the factory page
        wr(ruc_pkg::OFF_CTRL, 32'h0000_0005);
        fail_pages <= 8'h20;
        wr(ruc_pkg::OFF_CMD, 32'h0000_0001);
        wait_user();
        rd(ruc_pkg::OFF_STATUS, st(3'h1, 3'h0, 1, 1, 0), "load error status");
        fail_pages <= 8'h00;
        reconfig_n <= 1'b0;
        repeat (3) @(posedge pclk);
        reconfig_n <= 1'b1;
        wait_user();
        rd(ruc_pkg::OFF_STATUS, st(3'h4, 3'h0, 1, 1, 0), "pin status");
        // memory source refuses the asynchronous and reserved schemes
        for (s = 0; s < 4; s++) begin
            strap_scheme <= s[1:0];
            do_reset();
            repeat (40) @(posedge pclk);
            apb(1'b0, ruc_pkg::OFF_STATUS, 32'h0);
            chk(q & 32'h0000_1200, (s >= 2) ? 32'h0000_1000 : 32'h0000_0200, "scheme check");
        end
        strap_remote_mode <= 1'b0;
        strap_scheme <= 2'h2;
        strap_mem_source <= 1'b0;
        do_reset();
        wait_user();
        chk({29'h0, load_req.page}, 32'h1, "local page");
        rd(ruc_pkg::OFF_STATUS, st(3'h0, 3'h1, 0, 0, 0), "local status");
        chk({31'h0, app_active}, 32'h1, "local app");
        final_report();
    end
endmodule
`default_nettype wire
